// ---- tmd_pkg.sv ----
// Overview of operation
// - while writing, each falling timing edge loads the write buffer with the next line
// - while writing, each rising timing edge reverses write current in all heads
// - while reading outside mark recording, each rising timing edge strobes data and mark amplifiers
// - a positive pulse at strobe stores one, anything else stores zero
// - one word spans six lines of three bits, eighteen bits in all
// - outside mark recording, one mark bit per line, six bits form a code
// - reverse motion shows codes bit-reversed and inverted; decoding allows for it
// - complement image swaps octal digits and maps 0-7, 1-3, 2-5, 4-6
// - eight codes equal their image, 07, 25 and 70 among them
// - closing marks are images of opening marks in reverse order
// - only ten distinct mark codes are accepted, meaning depends on direction
// - code 73 forward outside data ends the forward parity group frame
// - code 10 forward means reverse parity group is buffered, data follows
// - code 70 marks every data frame except final and prefinal, any count
// - code 25 is first and last mark of a block and does nothing
// - code 55 forward and code 22 reverse mean end zone entered
// - code 73 forward in data means last word buffered, parity group next
// - code 10 in reverse means last word of block is buffered
// - up to 4096 blocks, lengths set only by the mark channel
// - no valid mark within six lines raises a mark channel error
// - checksum is inverted xor of each six bits with prior reverse checksum
// - code 26 is the forward block mark, code 45 its reverse form
package tmd_pkg;
  localparam int LINE_W = 3;
  localparam int WORD_W = 18;
  localparam int MARK_W = 6;
  localparam int BLK_W = 12;
  localparam logic [2:0] LINE_LAST = 3'h5;
  localparam logic [2:0] LINE_ONE = 3'h1;
  localparam logic [BLK_W-1:0] BLK_STEP = 12'h001;
  localparam logic [MARK_W-1:0] MARK_GUARD = 6'h29;
  localparam logic [MARK_W-1:0] MARK_GUARD_REV = 6'h1a;
  localparam logic [MARK_W-1:0] MARK_C10 = 6'h08;
  localparam logic [MARK_W-1:0] MARK_C73 = 6'h3b;
  localparam logic [MARK_W-1:0] MARK_BLOCK_FWD = 6'h16;
  localparam logic [MARK_W-1:0] MARK_BLOCK_REV = 6'h25;
  localparam logic [MARK_W-1:0] MARK_DATA = 6'h38;
  localparam logic [MARK_W-1:0] MARK_INTERBLOCK = 6'h15;
  localparam logic [MARK_W-1:0] MARK_END_FWD = 6'h2d;
  localparam logic [MARK_W-1:0] MARK_END_REV = 6'h12;

  typedef enum logic [3:0] {
    KIND_NONE = 4'h0,
    KIND_GUARD = 4'h1,
    KIND_BLOCK_FWD = 4'h2,
    KIND_BLOCK_REV = 4'h3,
    KIND_DATA = 4'h4,
    KIND_INTERBLOCK = 4'h5,
    KIND_C73 = 4'h6,
    KIND_C10 = 4'h7,
    KIND_END = 4'h8
  } tmd_kind_t;

  // gray along gap, head, data, tail
  typedef enum logic [1:0] {
    PH_GAP = 2'h0,
    PH_HEAD = 2'h1,
    PH_DATA = 2'h3,
    PH_TAIL = 2'h2
  } tmd_phase_t;

  function automatic logic [2:0] tmd_digit_img(input logic [2:0] d);
    case (d)
      3'h0: tmd_digit_img = 3'h7;
      3'h1: tmd_digit_img = 3'h3;
      3'h2: tmd_digit_img = 3'h5;
      3'h3: tmd_digit_img = 3'h1;
      3'h4: tmd_digit_img = 3'h6;
      3'h5: tmd_digit_img = 3'h2;
      3'h6: tmd_digit_img = 3'h4;
      default: tmd_digit_img = 3'h0;
    endcase
  endfunction : tmd_digit_img

  // digit order swapped, each digit mapped
  function automatic logic [5:0] tmd_cimg(input logic [5:0] c);
    tmd_cimg = {tmd_digit_img(c[2:0]), tmd_digit_img(c[5:3])};
  endfunction : tmd_cimg

  function automatic logic tmd_is_valid(input logic [5:0] c);
    case (c)
      MARK_GUARD, MARK_GUARD_REV, MARK_C10, MARK_C73, MARK_BLOCK_FWD,
      MARK_BLOCK_REV, MARK_DATA, MARK_INTERBLOCK, MARK_END_FWD,
      MARK_END_REV: tmd_is_valid = 1'b1;
      default: tmd_is_valid = 1'b0;
    endcase
  endfunction : tmd_is_valid
endpackage : tmd_pkg

// ---- tmd_mark_decode.sv ----
`timescale 1ns/100ps
`default_nettype none
module tmd_mark_decode (
  // code and motion
  input wire logic [tmd_pkg::MARK_W-1:0] code,
  input wire logic reverse,
  // result
  output logic valid,
  output var tmd_pkg::tmd_kind_t kind
);
  import tmd_pkg::*;

  assign valid = tmd_is_valid(code);

  // end codes only count in their own direction, otherwise no action
  always_comb
  begin
    case (code)
      MARK_BLOCK_FWD: kind = KIND_BLOCK_FWD;
      MARK_BLOCK_REV: kind = KIND_BLOCK_REV;
      MARK_DATA: kind = KIND_DATA;
      MARK_INTERBLOCK: kind = KIND_INTERBLOCK;
      MARK_C73: kind = KIND_C73;
      MARK_C10: kind = KIND_C10;
      MARK_END_FWD: kind = reverse ? KIND_GUARD : KIND_END;
      MARK_END_REV: kind = reverse ? KIND_END : KIND_GUARD;
      MARK_GUARD, MARK_GUARD_REV: kind = KIND_GUARD;
      default: kind = KIND_NONE;
    endcase
  end
endmodule : tmd_mark_decode
`default_nettype wire

// ---- tmd_track_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
module tmd_track_decoder (
  // system side
  input wire logic clk,
  input wire logic srst,
  // tape side clock
  input wire logic link_clk,
  // mode
  input wire logic writing,
  input wire logic reverse,
  input wire logic mark_record_mode,
  input wire logic eot_clear,
  // head amplifier pins
  input wire logic timing_track,
  input wire logic [tmd_pkg::LINE_W-1:0] data_pulse,
  input wire logic mark_pulse,
  output logic [tmd_pkg::LINE_W-1:0] write_current,
  output logic write_gate,
  // word transfer
  input wire logic [tmd_pkg::WORD_W-1:0] wr_word,
  output logic wr_word_take,
  output logic [tmd_pkg::WORD_W-1:0] rd_word,
  output logic rd_word_valid,
  // mark events
  output logic [tmd_pkg::MARK_W-1:0] mark_code,
  output logic mark_valid,
  output logic mark_error,
  output logic ev_block,
  output logic ev_data,
  output logic ev_final_fwd,
  output logic ev_check_fwd,
  output logic ev_check_rev,
  output logic ev_final_rev,
  output logic end_of_tape,
  output logic [tmd_pkg::BLK_W-1:0] block_number,
  output logic [tmd_pkg::MARK_W-1:0] block_checksum_character
);
  import tmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: synchronisers
  logic ls1, ls2, lrst;
  logic t1, t2, t3;
  logic [LINE_W:0] d1, d2;
  logic w1, w2, m1, m2;
  logic wt1, wt2, wt3;
  logic wr_tog;
  logic [LINE_W-1:0] wr_line_hold;
  logic [LINE_W-1:0] stage, wr_buf;
  logic [LINE_W-1:0] ln_data;
  logic ln_mark, ln_tog;
  logic t_pos, t_neg, wr_new, strobe;

  assign lrst = ls2;

  always_ff @(posedge link_clk)
  begin
    ls1 <= srst;
    ls2 <= ls1;
    t1 <= timing_track;
    t2 <= t1;
    d1 <= {mark_pulse, data_pulse};
    d2 <= d1;
    w1 <= writing;
    w2 <= w1;
    m1 <= mark_record_mode;
    m2 <= m1;
    wt1 <= wr_tog;
    wt2 <= wt1;
    // no reset here, so lifting reset never shows a false timing edge
    t3 <= t2;
  end

  assign t_pos = t2 & ~t3;
  assign t_neg = ~t2 & t3;
  assign wr_new = wt2 ^ wt3;
  assign strobe = t_pos & ~m2;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: write heads and read strobe
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      wt3 <= 1'b0;
      stage <= '0;
      write_gate <= 1'b0;
    end
    else
    begin
      wt3 <= wt2;
      write_gate <= w2;
      if (wr_new)
        stage <= wr_line_hold;
    end
  end

  // a zero starts with positive current and turns negative at the rising edge
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      wr_buf <= '0;
      write_current <= '0;
    end
    else if (w2 && t_neg)
    begin
      wr_buf <= stage;
      write_current <= ~stage;
    end
    else if (w2 && t_pos)
      write_current <= wr_buf;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      ln_data <= '0;
      ln_mark <= 1'b0;
      ln_tog <= 1'b0;
    end
    else if (strobe)
    begin
      ln_data <= w2 ? '0 : d2[LINE_W-1:0];
      ln_mark <= d2[LINE_W];
      ln_tog <= ~ln_tog;
    end
  end

  chk_write_load: assert property (@(posedge link_clk) disable iff (lrst)
    (w2 && t_neg) |=> (wr_buf == $past(stage)) && (write_current == ~wr_buf))
    else $error("write buffer not loaded at falling timing edge");
  chk_current_flip: assert property (@(posedge link_clk) disable iff (lrst)
    (w2 && t_pos && (write_current == ~wr_buf)) |=> write_current == ~$past(write_current))
    else $error("write current not reversed at rising timing edge");
  chk_strobe_only: assert property (@(posedge link_clk) disable iff (lrst)
    !strobe |=> $stable(ln_tog) && $stable(ln_mark))
    else $error("read buffer changed outside the strobe");

  ////////////////////////////////////////////////////////////////////////////
  // system domain: line events
  logic lt1, lt2, lt3;
  logic line_ev;
  logic [MARK_W-1:0] mark_sr, next_mark;
  logic dec_valid;
  tmd_kind_t dec_kind;
  logic [2:0] cnt;
  logic synced, accept, miss;
  tmd_phase_t phase, next_phase;
  logic [WORD_W-1:0] rd_sr, wr_sr, next_rd_word;
  logic [LINE_W-1:0] half, cs_line;
  logic odd;

  always_ff @(posedge clk)
  begin
    lt1 <= ln_tog;
    lt2 <= lt1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      lt3 <= 1'b0;
    else
      lt3 <= lt2;
  end

  // line data stays put for a whole line after the toggle
  assign line_ev = lt2 ^ lt3;
  assign next_mark = {mark_sr[MARK_W-2:0], ln_mark};
  assign next_rd_word = {rd_sr[WORD_W-LINE_W-1:0], ln_data};

  tmd_mark_decode u_dec (
    .code(next_mark),
    .reverse(reverse),
    .valid(dec_valid),
    .kind(dec_kind)
  );

  // a mark counts once a frame, or on any line while hunting
  assign accept = line_ev & dec_valid & (~synced | (cnt == LINE_LAST));
  assign miss = line_ev & ~accept & (cnt == LINE_LAST);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mark_sr <= '0;
      rd_sr <= '0;
      cnt <= '0;
      synced <= 1'b0;
    end
    else if (line_ev)
    begin
      mark_sr <= next_mark;
      rd_sr <= next_rd_word;
      cnt <= (accept || miss) ? '0 : cnt + LINE_ONE;
      synced <= accept | (synced & ~miss);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block phase
  always_comb
  begin
    next_phase = phase;
    case (phase)
      PH_GAP:
        if (dec_kind == KIND_BLOCK_FWD || dec_kind == KIND_BLOCK_REV)
          next_phase = PH_HEAD;
      PH_HEAD:
        if (dec_kind == KIND_DATA)
          next_phase = PH_DATA;
      PH_DATA:
        if ((dec_kind == KIND_C73 && !reverse) || (dec_kind == KIND_C10 && reverse))
          next_phase = PH_TAIL;
      PH_TAIL:
        if (dec_kind == KIND_INTERBLOCK)
          next_phase = PH_GAP;
      default: next_phase = PH_GAP;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      phase <= PH_GAP;
    else if (miss)
      phase <= PH_GAP;
    else if (accept)
      phase <= next_phase;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mark events
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mark_code <= '0;
      mark_valid <= 1'b0;
      mark_error <= 1'b0;
      ev_block <= 1'b0;
      ev_data <= 1'b0;
      ev_final_fwd <= 1'b0;
      ev_check_fwd <= 1'b0;
      ev_check_rev <= 1'b0;
      ev_final_rev <= 1'b0;
    end
    else
    begin
      if (accept)
        mark_code <= next_mark;
      mark_valid <= accept;
      mark_error <= miss;
      ev_block <= accept & ((dec_kind == KIND_BLOCK_FWD) | (dec_kind == KIND_BLOCK_REV));
      ev_data <= accept & (dec_kind == KIND_DATA);
      ev_final_fwd <= accept & (dec_kind == KIND_C73) & ~reverse & (phase == PH_DATA);
      ev_check_fwd <= accept & (dec_kind == KIND_C73) & ~reverse & (phase != PH_DATA);
      ev_check_rev <= accept & (dec_kind == KIND_C10) & ~reverse;
      ev_final_rev <= accept & (dec_kind == KIND_C10) & reverse;
    end
  end

  // set wins over the software clear
  always_ff @(posedge clk)
  begin
    if (srst)
      end_of_tape <= 1'b0;
    else if (accept && dec_kind == KIND_END)
      end_of_tape <= 1'b1;
    else if (eot_clear)
      end_of_tape <= 1'b0;
  end

  // counts block marks in the direction of motion, wraps at 4096
  always_ff @(posedge clk)
  begin
    if (srst)
      block_number <= '0;
    else if (accept && dec_kind == KIND_BLOCK_FWD && !reverse)
      block_number <= block_number + BLK_STEP;
    else if (accept && dec_kind == KIND_BLOCK_REV && reverse)
      block_number <= block_number - BLK_STEP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // word assembly and disassembly
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_word <= '0;
      rd_word_valid <= 1'b0;
    end
    else
    begin
      rd_word_valid <= accept & synced & ~writing;
      if (accept && synced && !writing)
        rd_word <= next_rd_word;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_sr <= '0;
      wr_line_hold <= '0;
      wr_tog <= 1'b0;
      wr_word_take <= 1'b0;
    end
    else
    begin
      wr_word_take <= line_ev & accept & writing;
      if (line_ev)
      begin
        wr_tog <= ~wr_tog;
        if (accept && writing)
        begin
          wr_line_hold <= wr_word[WORD_W-1:WORD_W-LINE_W];
          wr_sr <= {wr_word[WORD_W-LINE_W-1:0], {LINE_W{1'b0}}};
        end
        else
        begin
          wr_line_hold <= wr_sr[WORD_W-1:WORD_W-LINE_W];
          wr_sr <= {wr_sr[WORD_W-LINE_W-1:0], {LINE_W{1'b0}}};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checksum: pairs of lines folded by equivalence
  assign cs_line = writing ? wr_line_hold : ln_data;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      block_checksum_character <= '0;
      half <= '0;
      odd <= 1'b0;
    end
    else if (line_ev && accept && dec_kind == KIND_C10 && !reverse)
    begin
      block_checksum_character <= {rd_sr[LINE_W-1:0], ln_data};
      odd <= 1'b0;
    end
    else if (line_ev && phase == PH_DATA)
    begin
      odd <= ~odd;
      half <= cs_line;
      if (odd)
        block_checksum_character <= ~(block_checksum_character ^ {half, cs_line});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_mark_timeout: assert property (@(posedge clk) disable iff (srst)
    (line_ev && cnt == LINE_LAST && !dec_valid) |=> mark_error && !synced)
    else $error("missing mark not flagged");
  chk_frame_length: assert property (@(posedge clk) disable iff (srst)
    cnt <= LINE_LAST)
    else $error("mark frame longer than six lines");
  chk_image_closed: assert property (@(posedge clk) disable iff (srst)
    line_ev |-> tmd_is_valid(next_mark) == tmd_is_valid(tmd_cimg(next_mark)))
    else $error("valid set not closed under complement image");
  chk_self_image: assert property (@(posedge clk) disable iff (srst)
    (tmd_cimg(MARK_INTERBLOCK) == MARK_INTERBLOCK) && (tmd_cimg(MARK_DATA) == MARK_DATA))
    else $error("direction independent mark not its own image");
  chk_reverse_image: assert property (@(posedge clk) disable iff (srst)
    tmd_cimg(MARK_C73) == MARK_C10 && tmd_cimg(MARK_BLOCK_FWD) == MARK_BLOCK_REV)
    else $error("complement image table wrong");
  chk_end_sticky: assert property (@(posedge clk) disable iff (srst)
    (accept && dec_kind == KIND_END) ##1 !eot_clear |-> end_of_tape [*2])
    else $error("end of tape not held");
  chk_end_direction: assert property (@(posedge clk) disable iff (srst)
    (accept && next_mark == MARK_END_FWD && reverse && !end_of_tape && !eot_clear)
    |=> !end_of_tape)
    else $error("forward end mark taken in reverse");
  chk_block_step: assert property (@(posedge clk) disable iff (srst)
    (accept && dec_kind == KIND_BLOCK_FWD && !reverse)
    |=> block_number == $past(block_number) + BLK_STEP)
    else $error("block number not advanced");
  chk_word_data: assert property (@(posedge clk) disable iff (srst)
    rd_word_valid |-> rd_word[LINE_W-1:0] == $past(ln_data))
    else $error("read word not from last line");
  chk_final_rev: assert property (@(posedge clk) disable iff (srst)
    ev_final_rev |-> $past(reverse) && mark_code == MARK_C10)
    else $error("reverse final outside reverse motion");
  chk_no_op: assert property (@(posedge clk) disable iff (srst)
    (accept && dec_kind == KIND_INTERBLOCK) |=> !ev_block && !ev_data && mark_valid)
    else $error("interblock mark caused an action");

  cov_data_mark: cover property (@(posedge clk) disable iff (srst) ev_data);
  cov_final_fwd: cover property (@(posedge clk) disable iff (srst) ev_final_fwd);
  cov_mark_error: cover property (@(posedge clk) disable iff (srst) mark_error);
  cov_end_zone: cover property (@(posedge clk) disable iff (srst) $rose(end_of_tape));
endmodule : tmd_track_decoder
`default_nettype wire

// ---- tmd_tape_model.sv ----
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////
module tmd_tape_model (
  // head amplifier pins
  output logic timing_track,
  output logic [2:0] data_pulse,
  output logic mark_pulse,
  // write heads
  input wire logic [2:0] write_current,
  input wire logic write_gate,
  // recorded lines, newest in the low bits
  output logic [71:0] wr_hist
);
  initial
  begin
    timing_track = 1'b1;
    data_pulse = 3'h0;
    mark_pulse = 1'b0;
    wr_hist = '0;
  end

  ////////////////////////////////////////
  // pulses hold their level only around the rising timing edge
  task automatic send_line(input logic m, input logic [2:0] d);
    if (write_gate)
      wr_hist = {wr_hist[68:0], write_current};
    timing_track = 1'b0;
    mark_pulse = ~m;
    data_pulse = ~d;
    #1250;
    timing_track = 1'b1;
    mark_pulse = m;
    data_pulse = d;
    #750;
    mark_pulse = ~m;
    data_pulse = ~d;
    #500;
  endtask : send_line

  // first line carries the code msb and the word msbs
  task automatic send_frame(input logic [5:0] code, input logic [17:0] word);
    for (int i = 0; i < 6; i++)
      send_line(code[5-i], word[17-3*i -: 3]);
  endtask : send_frame
endmodule : tmd_tape_model
`default_nettype wire

// ---- tb_tape_mark_track_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
////////////////////////////////////////
module tb_tape_mark_track_decoder;
  import tmd_pkg::*;
  localparam logic [17:0] word_a = 18'h2d1c7;
  logic clk, srst, link_clk, writing, reverse, mark_record_mode, eot_clear;
  logic timing_track, mark_pulse, write_gate, wr_word_take, rd_word_valid, clr;
  logic mark_valid, mark_error, ev_block, ev_data, ev_final_fwd, ev_check_fwd;
  logic ev_check_rev, ev_final_rev, end_of_tape;
  logic [2:0] data_pulse, write_current;
  logic [17:0] rd_word;
  logic [17:0] wr_word = word_a;
  logic [17:0] rd_cap = 18'h00000;
  logic [5:0] mark_code, block_checksum_character;
  logic [11:0] block_number;
  logic [71:0] wr_hist;
  logic [7:0] seen = 8'h00;
  logic [7:0] take_cnt = 8'h00;
  int err_count, num_checks;

  tmd_track_decoder i_dut (
    .clk(clk), .srst(srst), .link_clk(link_clk), .writing(writing), .reverse(reverse),
    .mark_record_mode(mark_record_mode), .eot_clear(eot_clear),
    .timing_track(timing_track), .data_pulse(data_pulse), .mark_pulse(mark_pulse),
    .write_current(write_current), .write_gate(write_gate), .wr_word(wr_word),
    .wr_word_take(wr_word_take), .rd_word(rd_word), .rd_word_valid(rd_word_valid),
    .mark_code(mark_code), .mark_valid(mark_valid), .mark_error(mark_error),
    .ev_block(ev_block), .ev_data(ev_data), .ev_final_fwd(ev_final_fwd),
    .ev_check_fwd(ev_check_fwd), .ev_check_rev(ev_check_rev), .ev_final_rev(ev_final_rev),
    .end_of_tape(end_of_tape), .block_number(block_number),
    .block_checksum_character(block_checksum_character)
  );

  tmd_tape_model i_tape (
    .timing_track(timing_track), .data_pulse(data_pulse), .mark_pulse(mark_pulse),
    .write_current(write_current), .write_gate(write_gate), .wr_hist(wr_hist)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  ////////////////////////////////////////
  // event collector and write word supplier
  always @(posedge clk)
  begin
    if (clr)
      seen <= 8'h00;
    else
      seen <= seen | {mark_valid, mark_error, ev_block, ev_data,
                      ev_final_fwd, ev_check_fwd, ev_check_rev, ev_final_rev};
    if (rd_word_valid)
      rd_cap <= rd_word;
    if (wr_word_take)
    begin
      wr_word <= ~wr_word;
      take_cnt <= take_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////
  task automatic frame(input logic [5:0] code, input logic [17:0] word, input logic [7:0] exp);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    i_tape.send_frame(code, word);
    `CHK(seen, exp)
  endtask : frame

  task automatic set_mode(input logic w, input logic r, input logic m);
    @(posedge clk);
    writing <= w;
    reverse <= r;
    mark_record_mode <= m;
    repeat (10) @(posedge clk);
  endtask : set_mode

  task automatic clear_eot;
    @(posedge clk);
    eot_clear <= 1'b1;
    @(posedge clk);
    eot_clear <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(end_of_tape, 1'b0)
  endtask : clear_eot

  task automatic check_reset;
    `CHK(block_number, 12'h000)
    `CHK(end_of_tape, 1'b0)
    `CHK(write_gate, 1'b0)
    `CHK(mark_code, 6'h00)
  endtask : check_reset

  task automatic read_forward;
    frame(6'h15, 18'h00000, 8'h80);
    frame(6'h16, 18'h00000, 8'ha0);
    `CHK(block_number, 12'h001)
    frame(6'h38, word_a, 8'h90);
    `CHK(rd_cap, word_a)
    `CHK(mark_code, 6'h38)
    frame(6'h3b, word_a, 8'h88);
    `CHK(block_checksum_character, 6'h12)
    frame(6'h3b, 18'h00000, 8'h84);
    frame(6'h15, 18'h00000, 8'h80);
    frame(6'h08, 18'h0003a, 8'h82);
    `CHK(block_checksum_character, 6'h3a)
    frame(6'h29, 18'h00000, 8'h80);
    frame(6'h1a, 18'h00000, 8'h80);
    frame(6'h2d, 18'h00000, 8'h80);
    `CHK(end_of_tape, 1'b1)
    clear_eot;
    frame(6'h00, 18'h00000, 8'h40);
    frame(6'h15, 18'h00000, 8'h80);
  endtask : read_forward

  task automatic read_reverse;
    set_mode(1'b0, 1'b1, 1'b0);
    frame(6'h25, 18'h00000, 8'ha0);
    `CHK(block_number, 12'h000)
    frame(6'h08, 18'h00000, 8'h81);
    frame(6'h12, 18'h00000, 8'h80);
    `CHK(end_of_tape, 1'b1)
    clear_eot;
    frame(6'h2d, 18'h00000, 8'h80);
    `CHK(end_of_tape, 1'b0)
  endtask : read_reverse

  task automatic write_block;
    logic [7:0] t0;
    logic [2:0] frz;
    logic hit;
    set_mode(1'b1, 1'b0, 1'b0);
    t0 = take_cnt;
    frame(6'h15, 18'h00000, 8'h80);
    repeat (3) frame(6'h38, 18'h00000, 8'h90);
    `CHK(write_gate, 1'b1)
    `CHK(take_cnt - t0, 8'h04)
    hit = 1'b0;
    for (int k = 0; k <= 36; k++)
      if (wr_hist[k +: 36] === {word_a, ~word_a})
        hit = 1'b1;
    `CHK(hit, 1'b1)
    set_mode(1'b0, 1'b0, 1'b0);
    frz = write_current;
    frame(6'h38, 18'h1b2e5, 8'h90);
    `CHK(rd_cap, 18'h1b2e5)
    `CHK(write_current, frz)
    `CHK(write_gate, 1'b0)
  endtask : write_block

  task automatic record_mode;
    set_mode(1'b0, 1'b0, 1'b1);
    frame(6'h15, 18'h00000, 8'h00);
    set_mode(1'b0, 1'b0, 1'b0);
  endtask : record_mode

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run;
  end

  initial
  begin
    err_count = 0;
    num_checks = 0;
    srst = 1'b1;
    writing = 1'b0;
    reverse = 1'b0;
    mark_record_mode = 1'b0;
    eot_clear = 1'b0;
    clr = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    check_reset;
    read_forward;
    read_reverse;
    write_block;
    record_mode;
    complete_run;
  end
endmodule : tb_tape_mark_track_decoder
`default_nettype wire
